// >>> dds_pkg.sv
// dds_pkg: constants shared by the synthesis core and its host.
// assumes: both ends compile against this package first.
package dds_pkg;
	localparam int ACC_W = 28;
	localparam int PH_W = 12;
	localparam int DAC_W = 10;
	localparam int WORD_W = 16;
	localparam int HALF_W = 14;
	localparam int CNT_W = 4;
	// serial word address field, top two bits
	localparam logic [1:0] ADDR_CTRL = 2'h0;
	localparam logic [1:0] ADDR_FREQ_A = 2'h1;
	localparam logic [1:0] ADDR_FREQ_B = 2'h2;
	localparam logic [1:0] ADDR_PHASE = 2'h3;
	// control word bit positions
	localparam int CB_FULL = 13;
	localparam int CB_HIGH = 12;
	localparam int CB_FSEL = 11;
	localparam int CB_PSEL = 10;
	localparam int CB_RESET = 8;
	localparam int CB_MODE = 1;
	// phase word: bit 13 picks the offset register
	localparam int PB_SEL = 13;
	// pipeline from control write to converter input
	localparam int PIPE_LEN = 8;
	localparam logic [DAC_W-1:0] DAC_MID = 10'h200;
	// host register map over apb
	localparam logic [7:0] HA_DATA = 8'h00;
	localparam logic [7:0] HA_CMD = 8'h04;
	localparam logic [7:0] HA_STAT = 8'h08;
	localparam logic [7:0] HA_DIV = 8'h0C;
	localparam logic [7:0] DIV_RST = 8'h02;
endpackage : dds_pkg

// >>> dds_if.sv
// dds_if: three-wire serial link between host and synthesis core.
// assumes: the host is the only driver of all three wires.
`timescale 1ns/1ps
interface dds_if;
	logic serial_clk;
	logic serial_data_in;
	logic frame_sync_n;
	modport host (output serial_clk, output serial_data_in,
		output frame_sync_n);
	modport core (input serial_clk, input serial_data_in,
		input frame_sync_n);
endinterface : dds_if

// >>> dds_core.sv
// dds_core: phase accumulator, phase offset, sine table and serial port.
// assumes: link pins are synchronous to pclk and change slower than it.
//
// Contract
// - 28-bit accumulator adds word, wraps
// - output frequency is word times clock over 2^28
// - frequency word select picks word a or b
// - switching words keeps accumulator intact
// - add selected 12-bit offset to top bits
// - top 12 bits address sine table
// - mode bit d1 bypasses sine table
// - 10-bit sample to converter each cycle
// - each write carries one 16-bit word
// - bits accepted only while frame sync low
// - shift on serial clock falling edges
// - host releases sync after 16th edge
// - each 16 bits is a separate word
// - serial clock high when sync falls
// - host sets reset bit after power-up
// - reset bit clears accumulator, midscale out
// - reset bit spares word and control registers
// - host loads registers before clearing reset
// - first sample eight cycles after reset clears
// - top bits zero means control write
// - control bits sampled on master clock
// - new word reaches output within eight cycles; a frequency word here takes nine, one more for the accumulator
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module dds_core
	import dds_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// link
	dds_if.core link,
	// converter input and status
	output logic [dds_pkg::DAC_W-1:0] dac_code,
	output logic held_in_reset
);
	import dds_pkg::*;

	// delay stages after the table: addr, addr2, samp and out make four
	localparam int DLY_N = PIPE_LEN - 4;

	typedef struct packed {
		logic [2:0] sclk_s;
		logic [1:0] fs_s;
		logic [1:0] sd_s;
		logic [WORD_W-1:0] shift;
		logic [CNT_W-1:0] cnt;
		logic word_ok;
		logic [WORD_W-1:0] word;
		logic [WORD_W-1:0] ctrl;
		logic [ACC_W-1:0] fa;
		logic [ACC_W-1:0] fb;
		logic [PH_W-1:0] pa;
		logic [PH_W-1:0] pb;
		logic lsb_pending;
		logic [HALF_W-1:0] lsb_hold;
		logic [ACC_W-1:0] acc;
		logic [PH_W-1:0] addr;
		logic [PH_W-1:0] addr2;
		logic bypass;
		logic bypass2;
		logic hold;
		logic hold2;
		logic [DAC_W-1:0] samp;
		logic [DLY_N-1:0][DAC_W-1:0] dly;
		logic [DAC_W-1:0] out;
	} dc_state_t;

	dc_state_t s_r, s_nxt;

	// quarter-wave-free sine approximation by parabola, midscale offset
	function automatic logic [DAC_W-1:0] dc_sine(input logic [PH_W-1:0] a);
		logic [PH_W-2:0] x;
		logic [2*(PH_W-1)-1:0] p;
		logic [DAC_W-2:0] m;
		x = a[PH_W-2:0];
		p = 22'(x) * 22'(~x);
		m = p[2*(PH_W-1)-1 -: DAC_W-1];
		dc_sine = a[PH_W-1] ? DAC_MID - 10'(m) : DAC_MID + 10'(m);
	endfunction : dc_sine

	// destination field of a serial word
	function automatic logic [1:0] dc_dest(input logic [WORD_W-1:0] w);
		dc_dest = w[WORD_W-1 -: 2];
	endfunction : dc_dest

	logic fall;
	logic [ACC_W-1:0] step;
	logic [PH_W-1:0] offs;
	logic [HALF_W-1:0] lo14;
	logic [ACC_W-1:0] fw;

	always_comb begin
		s_nxt = s_r;
		s_nxt.sclk_s = {s_r.sclk_s[1:0], link.serial_clk};
		s_nxt.fs_s = {s_r.fs_s[0], link.frame_sync_n};
		s_nxt.sd_s = {s_r.sd_s[0], link.serial_data_in};
		s_nxt.word_ok = 1'b0;
		lo14 = '0;
		fw = '0;
		// edge seen on synchronised copies only
		fall = s_r.sclk_s[2] & ~s_r.sclk_s[1];
		if (s_r.fs_s[1]) begin
			s_nxt.cnt = '0;
		end else if (fall) begin
			s_nxt.shift = {s_r.shift[WORD_W-2:0], s_r.sd_s[1]};
			s_nxt.cnt = s_r.cnt + 4'h1;
			if (s_r.cnt == 4'hF) begin
				s_nxt.word_ok = 1'b1;
				s_nxt.word = {s_r.shift[WORD_W-2:0], s_r.sd_s[1]};
			end
		end

		// register update in master clock domain
		if (s_r.word_ok) begin
			lo14 = s_r.word[HALF_W-1:0];
			unique case (dc_dest(s_r.word))
				ADDR_CTRL: s_nxt.ctrl = s_r.word;
				ADDR_FREQ_A, ADDR_FREQ_B: begin
					fw = (dc_dest(s_r.word) == ADDR_FREQ_A) ?
						s_r.fa : s_r.fb;
					if (s_r.ctrl[CB_FULL]) begin
						if (s_r.lsb_pending) begin
							fw = {lo14, s_r.lsb_hold};
							s_nxt.lsb_pending = 1'b0;
						end else begin
							s_nxt.lsb_hold = lo14;
							s_nxt.lsb_pending = 1'b1;
						end
					end else if (s_r.ctrl[CB_HIGH]) begin
						fw[ACC_W-1 -: HALF_W] = lo14;
					end else begin
						fw[HALF_W-1:0] = lo14;
					end
					if (dc_dest(s_r.word) == ADDR_FREQ_A) begin
						s_nxt.fa = fw;
					end else begin
						s_nxt.fb = fw;
					end
				end
				ADDR_PHASE: begin
					if (s_r.word[PB_SEL]) begin
						s_nxt.pb = s_r.word[PH_W-1:0];
					end else begin
						s_nxt.pa = s_r.word[PH_W-1:0];
					end
				end
			endcase
		end

		// word and offset in use
		step = s_r.ctrl[CB_FSEL] ? s_r.fb : s_r.fa;
		offs = s_r.ctrl[CB_PSEL] ? s_r.pb : s_r.pa;

		// accumulator; select change never touches it
		if (s_r.ctrl[CB_RESET]) begin
			s_nxt.acc = '0;
		end else begin
			s_nxt.acc = s_r.acc + step;
		end

		// top bits plus offset, modulo wrap
		s_nxt.addr = s_r.ctrl[CB_RESET] ? '0 :
			s_r.acc[ACC_W-1 -: PH_W] + offs;
		s_nxt.bypass = s_r.ctrl[CB_MODE];
		s_nxt.addr2 = s_r.addr;
		s_nxt.bypass2 = s_r.bypass;

		// reset bit rides along so midscale lines up with the address
		s_nxt.hold = s_r.ctrl[CB_RESET];
		s_nxt.hold2 = s_r.hold;
		if (s_r.hold2) begin
			s_nxt.samp = DAC_MID;
		end else if (s_r.bypass2) begin
			s_nxt.samp = s_r.addr2[PH_W-1 -: DAC_W];
		end else begin
			s_nxt.samp = dc_sine(s_r.addr2);
		end

		// fixed delay: output lands PIPE_LEN cycles after a control or phase update, one cycle more after a frequency update
		s_nxt.dly[0] = s_r.samp;
		for (int i = 1; i < DLY_N; i++) begin
			s_nxt.dly[i] = s_r.dly[i-1];
		end
		s_nxt.out = s_r.dly[DLY_N-1];
	end

	// reset parks the core with the reset bit set, output at midscale
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
			s_r.sclk_s <= 3'h7;
			s_r.fs_s <= 2'h3;
			s_r.ctrl[CB_RESET] <= 1'b1;
			s_r.hold <= 1'b1;
			s_r.hold2 <= 1'b1;
			s_r.out <= DAC_MID;
			s_r.samp <= DAC_MID;
			s_r.dly <= {DLY_N{DAC_MID}};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign dac_code = s_r.out;
	assign held_in_reset = s_r.ctrl[CB_RESET];
endmodule : dds_core

// >>> dds_host.sv
// dds_host: apb slave that serialises 16-bit words onto the link.
// assumes: apb master follows standard setup/access protocol.
`timescale 1ns/1ps
module dds_host
	import dds_pkg::*;
(
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// link
	dds_if.host link
);
	import dds_pkg::*;

	typedef enum logic [1:0] {
		HS_IDLE = 2'b00,
		HS_LOW = 2'b01,
		HS_HIGH = 2'b10,
		HS_END = 2'b11
	} dh_st_t;

	typedef struct packed {
		dh_st_t st;
		logic [WORD_W-1:0] data;
		logic [WORD_W-1:0] sh;
		logic [CNT_W-1:0] bits;
		logic [7:0] div;
		logic [7:0] tick;
		logic sclk;
		logic sd;
		logic fs_n;
		logic [31:0] rd;
		logic rdy;
	} dh_state_t;

	dh_state_t s_r, s_nxt;
	logic acc_ph;

	always_comb begin
		s_nxt = s_r;
		acc_ph = psel & penable & ~s_r.rdy;
		s_nxt.rdy = acc_ph;
		s_nxt.rd = '0;
		if (acc_ph && !pwrite) begin
			unique case (paddr)
				HA_DATA: s_nxt.rd = {16'h0, s_r.data};
				HA_STAT: s_nxt.rd = {31'h0, s_r.st != HS_IDLE};
				HA_DIV: s_nxt.rd = {24'h0, s_r.div};
				default: s_nxt.rd = '0;
			endcase
		end
		if (acc_ph && pwrite) begin
			if (paddr == HA_DATA) s_nxt.data = pwdata[WORD_W-1:0];
			if (paddr == HA_DIV) s_nxt.div = pwdata[7:0];
		end
		s_nxt.tick = (s_r.tick == 8'h0) ? s_r.div : s_r.tick - 8'h1;
		unique case (s_r.st)
			HS_IDLE: begin
				s_nxt.sclk = 1'b1;
				s_nxt.fs_n = 1'b1;
				if (acc_ph && pwrite && paddr == HA_CMD) begin
					s_nxt.sh = s_r.data;
					s_nxt.fs_n = 1'b0;
					s_nxt.sd = s_r.data[WORD_W-1];
					s_nxt.bits = '0;
					s_nxt.tick = s_r.div;
					s_nxt.st = HS_HIGH;
				end
			end
			HS_HIGH: if (s_r.tick == 8'h0) begin
				s_nxt.sclk = 1'b0; // falling edge samples sd
				s_nxt.st = HS_LOW;
			end
			HS_LOW: if (s_r.tick == 8'h0) begin
				s_nxt.sclk = 1'b1;
				s_nxt.bits = s_r.bits + 4'h1;
				s_nxt.sh = {s_r.sh[WORD_W-2:0], 1'b0};
				s_nxt.sd = s_r.sh[WORD_W-2];
				s_nxt.st = (s_r.bits == 4'hF) ? HS_END : HS_HIGH;
			end
			HS_END: if (s_r.tick == 8'h0) begin
				s_nxt.fs_n = 1'b1;
				s_nxt.st = HS_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
			s_r.st <= HS_IDLE;
			s_r.div <= DIV_RST;
			s_r.sclk <= 1'b1;
			s_r.fs_n <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign prdata = s_r.rd;
	assign pready = s_r.rdy;
	assign pslverr = 1'b0;
	assign link.serial_clk = s_r.sclk;
	assign link.serial_data_in = s_r.sd;
	assign link.frame_sync_n = s_r.fs_n;
endmodule : dds_host

// >>> dds_monitor.sv
// dds_monitor: link framing and converter output checks.
// assumes: fed from the link interface and core outputs in the bench.
`timescale 1ns/1ps
module dds_monitor
	import dds_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// link
	input wire logic serial_clk,
	input wire logic serial_data_in,
	input wire logic frame_sync_n,
	// core outputs
	input wire logic [dds_pkg::DAC_W-1:0] dac_code,
	input wire logic held_in_reset
);
	import dds_pkg::*;
	logic sclk_r;
	logic [4:0] falls_r;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// serial clock falls seen inside a frame
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sclk_r <= 1'b1;
			falls_r <= 5'h00;
		end else begin
			sclk_r <= serial_clk;
			if (frame_sync_n)
				falls_r <= 5'h00;
			else if (sclk_r && !serial_clk)
				falls_r <= falls_r + 5'h01;
		end
	end
	a_sclk_at_sync: assert property ($fell(frame_sync_n) |-> serial_clk)
		else $error("serial clock low at frame start");
	a_word_falls: assert property ($rose(frame_sync_n) |->
		falls_r + 5'(sclk_r & ~serial_clk) == 5'h10)
		else $error("frame did not hold sixteen falls");
	a_frame_held: assert property ($fell(frame_sync_n) |=>
		!frame_sync_n [*8])
		else $error("frame sync released early");
	a_frame_gap: assert property ($rose(frame_sync_n) |=> frame_sync_n)
		else $error("no idle between frames");
	a_sclk_slow: assert property ($changed(serial_clk) |=>
		$stable(serial_clk) [*2])
		else $error("serial clock level too short");
	a_fall_framed: assert property ($fell(serial_clk) |-> !frame_sync_n)
		else $error("serial clock fell outside frame");
	a_reset_mid: assert property (
		held_in_reset [*8] ##1 held_in_reset |-> dac_code == DAC_MID)
		else $error("output not midscale in reset");
	a_first_sample: assert property ($fell(held_in_reset) |->
		(dac_code == DAC_MID) [*8])
		else $error("output left midscale too soon");
	c_frame: cover property ($fell(frame_sync_n));
	c_release: cover property ($fell(held_in_reset));
	c_data: cover property ($changed(serial_data_in));
endmodule : dds_monitor

// >>> dds_waveform_core_tb.sv
// dds_waveform_core_tb: apb writes through the host, core output checks.
// assumes: host and core meet over one dds_if instance.
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
	fail_count++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); \
	end end
module dds_waveform_core_tb;
	import dds_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic held_in_reset;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, seed, ev;
	logic [DAC_W-1:0] dac_code, d0;
	logic [31:0] exp_q[$];
	logic [15:0] words[6] = '{16'h2102, 16'h4000, 16'h4000, 16'h8000,
		16'h8010, 16'hC400};
	int fail_count = 0;
	int check_count = 0;
	int div;
	dds_if link_if();
	dds_core dds_core_inst(.pclk(pclk), .presetn(presetn), .link(link_if),
		.dac_code(dac_code), .held_in_reset(held_in_reset));
	dds_host dds_host_inst(.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link_if));
	dds_monitor dds_monitor_inst(.pclk(pclk), .presetn(presetn),
		.serial_clk(link_if.serial_clk),
		.serial_data_in(link_if.serial_data_in),
		.frame_sync_n(link_if.frame_sync_n), .dac_code(dac_code),
		.held_in_reset(held_in_reset));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk iff (pready === 1'b1));
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		apb(1'b0, a, 32'h00000000);
	endtask : rd_chk
	// one word out, then idle status once the frame is long over
	task automatic send(input logic [15:0] w);
		apb(1'b1, HA_DATA, {16'h0000, w});
		apb(1'b1, HA_CMD, 32'h00000001);
		repeat (40 * (div + 1) + 20) @(posedge pclk);
		rd_chk(HA_STAT, 32'h00000000);
	endtask : send
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			ev = exp_q.pop_front();
			`CHK("prdata", ev, prdata)
			`CHK("pslverr", 1'b0, pslverr)
		end
	end
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	initial begin
		repeat (20000) @(posedge pclk);
		fail_count++;
		end_of_test();
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		seed = xs(32'h6EE4);
		div = 2 + int'(seed[1:0]);
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		`CHK("held", 1'b1, held_in_reset)
		`CHK("dac", DAC_MID, dac_code)
		rd_chk(HA_DIV, {24'h000000, DIV_RST});
		rd_chk(8'h10, 32'h00000000);
		apb(1'b1, HA_DIV, 32'(div));
		rd_chk(HA_DIV, 32'(div));
		// reset held, words in halves, quarter-turn offset
		foreach (words[i])
			send(words[i]);
		`CHK("dac", DAC_MID, dac_code)
		send(16'h2002);
		`CHK("held", 1'b0, held_in_reset)
		`CHK("dac", 10'h100, dac_code)
		send(16'h2802);
		@(negedge pclk);
		d0 = dac_code;
		@(negedge pclk);
		`CHK("step", d0 + 10'h001, dac_code)
		@(posedge pclk);
		send(16'h2902);
		`CHK("dac", DAC_MID, dac_code)
		end_of_test();
	end
endmodule : dds_waveform_core_tb
